// File: include/hw_monitor_defs.svh
// Offsets, field positions, reset values and timing counts of the
// hardware-monitor mask bank. Included by the register bank and the host port model.
`ifndef HW_MONITOR_DEFS_SVH
`define HW_MONITOR_DEFS_SVH

`define PORT_BOOT_PROGRESS_CODE_A          3'h0
`define PORT_BOOT_PROGRESS_CODE_B          3'h4
`define PORT_INDEX           3'h5
`define PORT_DATA            3'h6

`define REG_MGMT_MASK_B      7'h44
`define REG_HOST_MASK_A      7'h45
`define REG_HOST_MASK_B      7'h46
`define REG_VID_FAN_DIV      7'h47
`define REG_SLAVE_ADDR       7'h48
`define REG_CHIP_RESET_ID    7'h49

`define RST_MGMT_MASK_B      8'h00
`define RST_HOST_MASK_A      8'h00
`define RST_HOST_MASK_B      8'h40
`define RST_FAN_DIV          4'h5
`define RST_SLAVE_ADDR       7'h2d
`define RST_INDEX            7'h00

`define BIT_RESET_EN         7
`define BIT_CHASSIS_CLR      7
`define BIT_CHIP_RESET       5
`define BOOT_PROGRESS_CODE_LAST            5'h1f

`define PULSE_TIME_MS        20
`define MCLK_PERIOD_NS       50
`define PULSE_CYCLES_CALC    ((`PULSE_TIME_MS * 1000000 + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// File: include/hw_monitor_pkg.sv
// Types shared by the hardware-monitor mask bank.
// Assumes the constants header is on the include path.
package hw_monitor_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [2:0] port_sel_t;
    typedef enum logic [0:0] {
        PULSE_IDLE = 1'b0,
        PULSE_LOW  = 1'b1
    } pulse_state_t;
endpackage

// File: rtl/hw_monitor_irq_mask_regs.sv
// Mask registers, fan divisor, slave address, chip reset and boot code RAM.
// Assumes status flags and configuration bits come from neighbouring logic.
//
// What this block does
// RULE1: Mgmt mask B bits 0-6 block bank-B flags
// RULE2: Mask B bit 7 gates reset pulse request
// RULE3: Host mask A blocks bank-A flags
// RULE4: Host mask B bits 0-6 block bank-B flags
// RULE5: Host mask B powers up as 40h
// RULE6: Chassis clear bit drives 20 ms pulse
// RULE7: 47h low nibble reads voltage-ID pins
// RULE8: 47h bits 5:4 pick fan 1 divisor
// RULE9: 47h bits 7:6 pick fan 2 divisor
// RULE10: Fan divisor bits power up as 0101
// RULE11: Slave address resets 2Dh, bit 7 zero
// RULE12: 49h shows pin 4 and identity bit
// RULE13: Chip reset bit restores every register
// RULE14: Boot code writes store and advance pointer
// RULE15: Pointer at 1Fh flags overflow, stops
// RULE16: Reads use own pointer, never overflow
// RULE17: Mgmt mask B, host mask A reset 00h
// RULE18: Overflow flag is bank-B status bit 5
// RULE19: Enabled reset request drives 20 ms pulse
// RULE20: Config bits enable the two outputs
// RULE21: Output asserts on any unmasked flag
`timescale 1ns/10ps
`default_nettype none
`include "hw_monitor_defs.svh"

module hw_monitor_irq_mask_regs #(
    parameter int PULSE_CYCLES = `PULSE_CYCLES_CALC,
    parameter bit ID_BIT       = 1'b0   // Arbitrary value
) (
    input  wire logic                      mclk,
    input  wire logic                      rst_n,
    input  wire hw_monitor_pkg::port_sel_t port_sel,
    input  wire logic                      port_wr,
    input  wire logic                      port_rd,
    input  wire hw_monitor_pkg::byte_t     port_wdata,
    output var  hw_monitor_pkg::byte_t     port_rdata,
    input  wire hw_monitor_pkg::byte_t     status_bank_a,
    input  wire logic [6:0]                status_bank_b,
    input  wire hw_monitor_pkg::byte_t     mgmt_mask_a,
    input  wire logic                      ovf_clear,
    input  wire logic                      cfg_mgmt_en,
    input  wire logic                      cfg_host_en,
    input  wire logic                      cfg_int_clear,
    input  wire logic                      cfg_reset_req,
    input  wire logic                      init_req,
    input  wire logic [3:0]                voltage_id_low_pins,
    input  wire logic                      voltage_id_pin_4,
    output var  logic                      mgmt_interrupt_out_n,
    output var  logic                      host_irq_out_n,
    output var  logic                      reset_pin_n,
    output var  logic                      chassis_pin_o,
    output var  logic                      chassis_pin_oe_n,
    output var  logic                      cfg_reset_done,
    output var  logic                      ovf_flag,
    output var  logic [1:0]                tach_input_1_div_code,
    output var  logic [1:0]                tach_input_2_div_code,
    output var  logic [6:0]                slave_addr,
    output var  logic                      soft_reset_out
);
    import hw_monitor_pkg::*;

    localparam int CNT_W = $clog2(PULSE_CYCLES + 1);

    if (PULSE_CYCLES < 1) begin : g_bad_pulse
        $error("PULSE_CYCLES must be at least one");
    end

    logic [7:0] mgmt_mask_b_q;
    logic [7:0] host_mask_a_q;
    logic [7:0] host_mask_b_q;
    logic [3:0] fan_div_q;
    logic [6:0] slave_q;
    logic [6:0] index_q;
    logic [4:0] wptr_q;
    logic [4:0] rptr_q;
    logic       ovf_q;
    logic       soft_q;
    logic       mgmt_n_q;
    logic       host_n_q;
    logic [7:0] rdata_q;
    byte_t      boot_progress_code_code_ram [32];
    logic [1:0] pulse_go;
    logic [1:0] pulse_done;
    logic [1:0] pulse_pin_n;
    byte_t      rd_mux;

    // Decode
    wire reg_rst   = !rst_n || soft_q;
    wire part_rst  = reg_rst || init_req;
    wire wr_data   = port_wr && (port_sel == `PORT_DATA);
    wire wr_index  = port_wr && (port_sel == `PORT_INDEX);
    wire in_boot_progress_code   = (index_q[6:5] == 2'b00);
    wire boot_progress_code_wr   = port_wr && ((port_sel == `PORT_BOOT_PROGRESS_CODE_A) || (port_sel == `PORT_BOOT_PROGRESS_CODE_B));
    wire boot_progress_code_rd   = port_rd && ((port_sel == `PORT_INDEX) || (port_sel == `PORT_DATA)) && in_boot_progress_code;
    wire wr_mmb    = wr_data && (index_q == `REG_MGMT_MASK_B);
    wire wr_hma    = wr_data && (index_q == `REG_HOST_MASK_A);
    wire wr_hmb    = wr_data && (index_q == `REG_HOST_MASK_B);
    wire wr_fan    = wr_data && (index_q == `REG_VID_FAN_DIV);
    wire wr_slave  = wr_data && (index_q == `REG_SLAVE_ADDR);
    wire wr_chip   = wr_data && (index_q == `REG_CHIP_RESET_ID);
    wire wptr_full = (wptr_q == `BOOT_PROGRESS_CODE_LAST);

    // RULE18: Overflow sits at bit 5
    wire [6:0] stat_b = {status_bank_b[6], ovf_q, status_bank_b[4:0]};

    // RULE1: Mgmt masking
    wire mgmt_hit = |(status_bank_a & ~mgmt_mask_a) || |(stat_b & ~mgmt_mask_b_q[6:0]);
    // RULE3: Host masking
    wire host_hit_a = |(status_bank_a & ~host_mask_a_q);
    // RULE4: Host masking
    wire host_hit = host_hit_a || |(stat_b & ~host_mask_b_q[6:0]);

    // RULE2: Reset enable gates
    assign pulse_go[0] = cfg_reset_req && mgmt_mask_b_q[`BIT_RESET_EN] && !pulse_done[0];
    assign pulse_go[1] = host_mask_b_q[`BIT_CHASSIS_CLR] && !pulse_done[1];

    // Pulse engines run off the power-on reset only, so a chip reset
    // write cannot cut a pulse already on the pin short.
    for (genvar ch = 0; ch < 2; ch++) begin : g_pulse
        pulse_state_t     st_q;
        pulse_state_t     st_d;
        logic [CNT_W-1:0] cnt_q;
        logic             pin_q;
        logic             done_q;
        wire cnt_end = (cnt_q == CNT_W'(PULSE_CYCLES - 1));
        always_comb begin
            st_d = st_q;
            case (st_q)
                PULSE_IDLE: if (pulse_go[ch]) st_d = PULSE_LOW;
                PULSE_LOW:  if (cnt_end) st_d = PULSE_IDLE;
                default:    st_d = PULSE_IDLE;
            endcase
        end
        // RULE6: Timed low pulse
        // RULE19: Timed low pulse
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                st_q   <= PULSE_IDLE;
                cnt_q  <= '0;
                pin_q  <= 1'b1;
                done_q <= 1'b0;
            end else begin
                st_q   <= st_d;
                cnt_q  <= (st_q == PULSE_LOW && !cnt_end) ? cnt_q + 1'b1 : '0;
                pin_q  <= (st_d != PULSE_LOW);
                done_q <= (st_q == PULSE_LOW) && cnt_end;
            end
        end
        assign pulse_done[ch]  = done_q;
        assign pulse_pin_n[ch] = pin_q;
    end

    // RULE17: Mask reset values
    // RULE5: Host mask B default
    always_ff @(posedge mclk) begin
        if (part_rst) begin
            mgmt_mask_b_q <= `RST_MGMT_MASK_B;
            host_mask_a_q <= `RST_HOST_MASK_A;
            host_mask_b_q <= `RST_HOST_MASK_B;
        end else begin
            if (wr_mmb) mgmt_mask_b_q <= port_wdata;
            if (wr_hma) host_mask_a_q <= port_wdata;
            // RULE6: Self clearing bit
            if (wr_hmb) host_mask_b_q <= port_wdata;
            else if (pulse_done[1]) host_mask_b_q[`BIT_CHASSIS_CLR] <= 1'b0;
        end
    end

    // RULE10: Divisor defaults
    // RULE8: Fan 1 code
    // RULE9: Fan 2 code
    always_ff @(posedge mclk) begin
        if (part_rst) begin
            fan_div_q <= `RST_FAN_DIV;
            index_q   <= `RST_INDEX;
        end else begin
            if (wr_fan) fan_div_q <= port_wdata[7:4];
            if (wr_index) index_q <= port_wdata[6:0];
        end
    end

    // RULE11: Slave address
    // Configuration init leaves the slave address alone; chip reset does not.
    always_ff @(posedge mclk) begin
        if (reg_rst) slave_q <= `RST_SLAVE_ADDR;
        else if (wr_slave) slave_q <= port_wdata[6:0];
    end

    // RULE13: Chip reset pulse
    always_ff @(posedge mclk) begin
        if (!rst_n) soft_q <= 1'b0;
        else soft_q <= wr_chip && port_wdata[`BIT_CHIP_RESET] && !soft_q;
    end

    // RULE14: Store and advance
    // RULE15: Stop at last
    always_ff @(posedge mclk) begin
        if (part_rst) begin
            wptr_q <= '0;
            rptr_q <= '0;
            ovf_q  <= 1'b0;
        end else begin
            if (boot_progress_code_wr && !wptr_full) wptr_q <= wptr_q + 5'h01;
            // RULE16: Separate read pointer
            if (boot_progress_code_rd) rptr_q <= rptr_q + 5'h01;
            // Set wins over a clear in the same cycle
            if (boot_progress_code_wr && wptr_full) ovf_q <= 1'b1;
            else if (ovf_clear) ovf_q <= 1'b0;
        end
    end

    // RAM contents survive resets; only the pointers and the overflow flag return home.
    always_ff @(posedge mclk) begin
        if (boot_progress_code_wr) boot_progress_code_code_ram[wptr_q] <= port_wdata;
    end

    // RULE7: Live pin nibble
    // RULE12: Pin 4 and identity
    always_comb begin
        case (index_q)
            `REG_MGMT_MASK_B:   rd_mux = mgmt_mask_b_q;
            `REG_HOST_MASK_A:   rd_mux = host_mask_a_q;
            `REG_HOST_MASK_B:   rd_mux = host_mask_b_q;
            `REG_VID_FAN_DIV:   rd_mux = {fan_div_q, voltage_id_low_pins};
            `REG_SLAVE_ADDR:    rd_mux = {1'b0, slave_q};
            `REG_CHIP_RESET_ID: rd_mux = {ID_BIT, 6'h00, voltage_id_pin_4};
            default:            rd_mux = in_boot_progress_code ? boot_progress_code_code_ram[rptr_q] : 8'h00;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) rdata_q <= 8'h00;
        else if (port_rd) rdata_q <= (port_sel == `PORT_INDEX) ? {1'b0, index_q} : rd_mux;
    end

    // RULE20: Output enables
    // RULE21: Any unmasked flag
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mgmt_n_q <= 1'b1;
            host_n_q <= 1'b1;
        end else begin
            mgmt_n_q <= !(cfg_mgmt_en && !cfg_int_clear && mgmt_hit);
            host_n_q <= !(cfg_host_en && !cfg_int_clear && host_hit);
        end
    end

    assign port_rdata           = rdata_q;
    assign mgmt_interrupt_out_n = mgmt_n_q;
    assign host_irq_out_n       = host_n_q;
    assign reset_pin_n          = pulse_pin_n[0];
    assign chassis_pin_o        = 1'b0 & pulse_pin_n[1];
    assign chassis_pin_oe_n     = pulse_pin_n[1];
    assign cfg_reset_done       = pulse_done[0];
    assign ovf_flag             = ovf_q;
    assign tach_input_1_div_code        = fan_div_q[1:0];
    assign tach_input_2_div_code        = fan_div_q[3:2];
    assign slave_addr           = slave_q;
    assign soft_reset_out       = soft_q;

    // Helper: length of the chassis low pulse
    logic [CNT_W:0] ast_low_cnt;
    always_ff @(posedge mclk) begin
        if (!rst_n || chassis_pin_oe_n) ast_low_cnt <= '0;
        else ast_low_cnt <= ast_low_cnt + 1'b1;
    end

    AST_MGMT_MASKED: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
        !mgmt_hit |=> mgmt_interrupt_out_n)
        else $error("Mgmt output asserted with all flags masked");
    AST_RESET_GATED: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
        (reset_pin_n && !pulse_go[0]) |=> reset_pin_n)
        else $error("Reset pulse started without enable");
    AST_HOST_MASKED: assert property (@(posedge mclk) disable iff (!rst_n) // RULE4
        !host_hit |=> host_irq_out_n)
        else $error("Host output asserted with all flags masked");
    AST_HOST_RAISED: assert property (@(posedge mclk) disable iff (!rst_n) // RULE21
        (cfg_host_en && !cfg_int_clear && host_hit_a) |=> !host_irq_out_n)
        else $error("Unmasked bank A flag did not reach host output");
    AST_SOFT_DEFAULTS: assert property (@(posedge mclk) disable iff (!rst_n) // RULE13
        soft_q |=> (host_mask_b_q == 8'h40 && mgmt_mask_b_q == 8'h00 && slave_q == 7'h2d && wptr_q == 5'h00))
        else $error("Chip reset left a register off its default");
    AST_CHASSIS_LEN: assert property (@(posedge mclk) disable iff (!rst_n) // RULE6
        $rose(chassis_pin_oe_n) |-> (ast_low_cnt == (CNT_W+1)'(PULSE_CYCLES))
            ##1 (!host_mask_b_q[7] || $past(wr_hmb)))
        else $error("Chassis pulse length or self clear wrong");
    AST_PTR_ADVANCE: assert property (@(posedge mclk) disable iff (!rst_n || soft_q || init_req) // RULE14
        (boot_progress_code_wr && !wptr_full) |=> (wptr_q == $past(wptr_q) + 5'h01 && !ovf_q == !$past(ovf_q)))
        else $error("Write pointer did not advance");
    AST_OVF_STOP: assert property (@(posedge mclk) disable iff (!rst_n || soft_q || init_req) // RULE15
        (boot_progress_code_wr && wptr_full) |=> (ovf_flag && wptr_q == 5'h1f) ##1 (wptr_q == 5'h1f || $past(init_req)))
        else $error("Overflow not flagged or pointer moved");
    AST_READ_NO_OVF: assert property (@(posedge mclk) disable iff (!rst_n) // RULE16
        (boot_progress_code_rd && !boot_progress_code_wr && !ovf_q) |=> !ovf_flag)
        else $error("Boot code read raised overflow");
    AST_VID_READ: assert property (@(posedge mclk) disable iff (!rst_n) // RULE7
        (port_rd && port_sel == 3'h6 && index_q == 7'h47) |=> port_rdata[3:0] == $past(voltage_id_low_pins))
        else $error("Pin nibble not returned");
    AST_SLAVE_TOP: assert property (@(posedge mclk) disable iff (!rst_n) // RULE11
        (port_rd && port_sel == 3'h6 && index_q == 7'h48) |=> !port_rdata[7])
        else $error("Slave address bit 7 not zero");

endmodule // hw_monitor_irq_mask_regs
`default_nettype wire

// File: sim/host_port_model.sv
// Host processor model on the port bus: index/data and boot-code accesses.
// Assumes the bench calls its tasks; every change lands on a falling mclk edge.
`timescale 1ns/10ps
`default_nettype none
`include "hw_monitor_defs.svh"
module host_port_model (
    input  wire logic                      mclk,
    output var  hw_monitor_pkg::port_sel_t port_sel,
    output var  logic                      port_wr,
    output var  logic                      port_rd,
    output var  hw_monitor_pkg::byte_t     port_wdata,
    input  wire hw_monitor_pkg::byte_t     port_rdata
);
    import hw_monitor_pkg::*;
    initial begin
        port_sel   = 3'h0;
        port_wr    = 1'b0;
        port_rd    = 1'b0;
        port_wdata = 8'h00;
    end
    // One strobe for one edge; released data is inverted, never left stale
    task automatic access(input port_sel_t s, input logic w, input byte_t d);
        @(negedge mclk);
        port_sel   = s;
        port_wr    = w;
        port_rd    = !w;
        port_wdata = d;
        @(negedge mclk);
        port_wr    = 1'b0;
        port_rd    = 1'b0;
        port_wdata = ~d;
    endtask
    task automatic reg_wr(input byte_t idx, input byte_t d);
        access(`PORT_INDEX, 1'b1, idx);
        access(`PORT_DATA, 1'b1, d);
    endtask
    // Read data is registered on the read edge, taken at the release
    task automatic reg_rd(input byte_t idx, output byte_t d);
        access(`PORT_INDEX, 1'b1, idx);
        access(`PORT_DATA, 1'b0, 8'h00);
        d = port_rdata;
    endtask
endmodule // host_port_model
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench: register table, masks, pulses, boot-code RAM.
// Assumes the host model drives the port bus; flags and config come from here.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin n_fail++; \
    $display("wrong value %s expected %h seen %h", nm, ex, got); end end
module tb;
    import hw_monitor_pkg::*;
    typedef struct packed {byte_t idx; logic we; byte_t wd; byte_t ex;} row_t;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    port_sel_t  port_sel;
    logic       port_wr, port_rd;
    byte_t      port_wdata, port_rdata, rd;
    byte_t      status_bank_a = 8'h00;
    logic [6:0] status_bank_b = 7'h00;
    byte_t      mgmt_mask_a = 8'h00;
    logic       ovf_clear = 1'b0;
    logic       cfg_mgmt_en = 1'b1;
    logic       cfg_host_en = 1'b1;
    logic       cfg_int_clear = 1'b0;
    logic       cfg_reset_req = 1'b0;
    logic       init_req = 1'b0;
    logic [3:0] voltage_id_low_pins = 4'ha;
    logic       voltage_id_pin_4 = 1'b1;
    logic       mgmt_interrupt_out_n, host_irq_out_n, reset_pin_n, chassis_pin_o, chassis_pin_oe_n;
    logic       cfg_reset_done, ovf_flag, soft_reset_out;
    logic [1:0] tach_input_1_div_code, tach_input_2_div_code;
    logic [6:0] slave_addr;
    int         n_fail = 0;
    int         samples_checked = 0;
    int         n;
    int         n_done = 0;
    // Reset reads first, then writes over writable, read-only and unmapped places
    row_t rows [13] = '{'{8'h44, 1'b0, 8'h00, 8'h00}, '{8'h45, 1'b0, 8'h00, 8'h00},
        '{8'h46, 1'b0, 8'h00, 8'h40}, '{8'h47, 1'b0, 8'h00, 8'h5a}, '{8'h48, 1'b0, 8'h00, 8'h2d},
        '{8'h49, 1'b0, 8'h00, 8'h01}, '{8'h44, 1'b1, 8'h7f, 8'h7f}, '{8'h45, 1'b1, 8'ha5, 8'ha5},
        '{8'h46, 1'b1, 8'h3f, 8'h3f}, '{8'h48, 1'b1, 8'hff, 8'h7f}, '{8'h49, 1'b1, 8'h9e, 8'h01},
        '{8'h47, 1'b1, 8'hff, 8'hfa}, '{8'h4a, 1'b1, 8'hff, 8'h00}};
    hw_monitor_irq_mask_regs #(.PULSE_CYCLES(8)) dut (.mclk, .rst_n, .port_sel, .port_wr, .port_rd,
        .port_wdata, .port_rdata, .status_bank_a, .status_bank_b, .mgmt_mask_a, .ovf_clear,
        .cfg_mgmt_en, .cfg_host_en, .cfg_int_clear, .cfg_reset_req, .init_req, .voltage_id_low_pins,
        .voltage_id_pin_4, .mgmt_interrupt_out_n, .host_irq_out_n, .reset_pin_n, .chassis_pin_o,
        .chassis_pin_oe_n, .cfg_reset_done, .ovf_flag, .tach_input_1_div_code, .tach_input_2_div_code, .slave_addr,
        .soft_reset_out);
    host_port_model host (.mclk, .port_sel, .port_wr, .port_rd, .port_wdata, .port_rdata);
    initial begin
        forever #25 mclk = ~mclk;
    end
    task automatic final_report();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic irq_chk(input logic m, input logic h);
        repeat (2) @(negedge mclk);
        `CHK("mgmt_irq", m, mgmt_interrupt_out_n)
        `CHK("host_irq", h, host_irq_out_n)
    endtask
    // Bounded window; the request drops when done is seen
    task automatic pulse_len(input logic chassis, output int k);
        k = 0;
        repeat (40) begin
            @(negedge mclk);
            if ((chassis ? chassis_pin_oe_n : reset_pin_n) === 1'b0) begin
                k++;
            end
            if (cfg_reset_done === 1'b1) begin
                cfg_reset_req = 1'b0;
                n_done++;
            end
        end
    endtask
    initial begin
        repeat (12) @(negedge mclk);
        rst_n = 1'b1;
        `CHK("slave", 7'h2d, slave_addr)
        `CHK("fan_codes", 4'h5, ({tach_input_2_div_code, tach_input_1_div_code}))
        for (int i = 0; i < 13; i++) begin
            if (rows[i].we) begin
                host.reg_wr(rows[i].idx, rows[i].wd);
            end
            host.reg_rd(rows[i].idx, rd);
            `CHK("reg", rows[i].ex, rd)
        end
        for (int k = 0; k < 4; k++) begin
            host.reg_wr(8'h47, {2'(3 - k), 2'(k), 4'h0});
            `CHK("fan_codes", ({2'(3 - k), 2'(k)}), ({tach_input_2_div_code, tach_input_1_div_code}))
        end
        status_bank_b = 7'h01;
        irq_chk(1'b1, 1'b1);
        host.reg_wr(8'h44, 8'h00);
        irq_chk(1'b0, 1'b1);
        host.reg_wr(8'h46, 8'h00);
        irq_chk(1'b0, 1'b0);
        status_bank_b = 7'h00;
        status_bank_a = 8'h01;
        irq_chk(1'b0, 1'b1);
        cfg_mgmt_en = 1'b0;
        irq_chk(1'b1, 1'b1);
        cfg_mgmt_en = 1'b1;
        host.reg_wr(8'h45, 8'h00);
        mgmt_mask_a = 8'h01;
        irq_chk(1'b1, 1'b0);
        cfg_int_clear = 1'b1;
        irq_chk(1'b1, 1'b1);
        cfg_int_clear = 1'b0;
        cfg_host_en = 1'b0;
        irq_chk(1'b1, 1'b1);
        status_bank_a = 8'h00;
        cfg_host_en = 1'b1;
        cfg_reset_req = 1'b1;
        pulse_len(1'b0, n);
        `CHK("gated_reset", 0, n)
        cfg_reset_req = 1'b0;
        host.reg_wr(8'h44, 8'h80);
        cfg_reset_req = 1'b1;
        pulse_len(1'b0, n);
        `CHK("reset_len", 8, n)
        `CHK("reset_done", 1, n_done)
        host.reg_wr(8'h46, 8'hc0);
        pulse_len(1'b1, n);
        `CHK("chassis_len", 8, n)
        `CHK("chassis_lvl", 1'b0, chassis_pin_o)
        host.reg_rd(8'h46, rd);
        `CHK("chassis_clr", 8'h40, rd)
        for (int i = 0; i < 32; i++) begin
            `CHK("ovf", 1'b0, ovf_flag)
            host.access(i[0] ? 3'h4 : 3'h0, 1'b1, 8'(8'h10 + i));
        end
        `CHK("ovf", 1'b1, ovf_flag)
        host.access(3'h0, 1'b1, 8'hee);
        host.access(3'h5, 1'b1, 8'h00);
        for (int i = 0; i < 32; i++) begin
            host.access(3'h6, 1'b0, 8'h00);
            `CHK("ram", (i == 31) ? 8'hee : 8'(8'h10 + i), port_rdata)
        end
        ovf_clear = 1'b1;
        @(negedge mclk);
        ovf_clear = 1'b0;
        host.reg_rd(8'h00, rd);
        `CHK("ovf_after_rd", 1'b0, ovf_flag)
        host.reg_wr(8'h45, 8'hff);
        host.reg_wr(8'h49, 8'h20);
        `CHK("soft_reset", 1'b1, soft_reset_out)
        host.reg_rd(8'h45, rd);
        `CHK("chip_rst_45", 8'h00, rd)
        host.reg_rd(8'h48, rd);
        `CHK("chip_rst_48", 8'h2d, rd)
        host.access(3'h4, 1'b1, 8'h77);
        host.reg_rd(8'h00, rd);
        `CHK("wptr_rst", 8'h77, rd)
        voltage_id_low_pins = 4'h5;
        voltage_id_pin_4 = 1'b0;
        host.reg_rd(8'h47, rd);
        `CHK("vid_live", 8'h55, rd)
        host.reg_rd(8'h49, rd);
        `CHK("voltage_id_pin_4_live", 8'h00, rd)
        host.reg_wr(8'h45, 8'hff);
        host.reg_wr(8'h48, 8'h11);
        init_req = 1'b1;
        @(negedge mclk);
        init_req = 1'b0;
        host.reg_rd(8'h45, rd);
        `CHK("init_45", 8'h00, rd)
        host.reg_rd(8'h48, rd);
        `CHK("init_48", 8'h11, rd)
        host.reg_wr(8'h46, 8'h3f);
        rst_n = 1'b0;
        repeat (2) @(negedge mclk);
        rst_n = 1'b1;
        `CHK("rst_fan", 4'h5, ({tach_input_2_div_code, tach_input_1_div_code}))
        `CHK("rst_slave", 7'h2d, slave_addr)
        host.reg_rd(8'h46, rd);
        `CHK("rst_46", 8'h40, rd)
        final_report();
    end
endmodule // tb
`default_nettype wire
